// ### design/rfc_pkg.sv
// constants and types for the calibrated calendar clock
// Overview of operation
// - binary mode steps by 512 cycles up and 256 cycles down.
// - bcd mode up correction steps by 1024 cycles per step.
// - bcd mode down correction steps by 512 cycles per step.
// - a time register write changes only the addressed register.
package rfc_pkg;
   // timing
   localparam int unsigned CLK_MHZ        = 125;
   localparam int unsigned SEC_US         = 1_000_000;
   localparam int unsigned SEC_CYCLES_DEF = SEC_US * CLK_MHZ;
   localparam logic [15:0] STEP_UP_BIN    = 16'h0200;
   localparam logic [15:0] STEP_DN_BIN    = 16'h0100;
   localparam logic [15:0] STEP_UP_BCD    = 16'h0400;
   localparam logic [15:0] STEP_DN_BCD    = 16'h0200;
   // bus
   localparam int unsigned ADDR_W         = 12;
   localparam logic [1:0]  RESP_OKAY      = 2'h0;
   localparam logic [1:0]  RESP_SLVERR    = 2'h2;
   // register byte offsets
   localparam logic [11:0] ADDR_CTRL      = 12'h000;
   localparam logic [11:0] ADDR_CAL       = 12'h004;
   localparam logic [11:0] ADDR_SEC       = 12'h008;
   localparam logic [11:0] ADDR_MIN       = 12'h00C;
   localparam logic [11:0] ADDR_HOUR      = 12'h010;
   localparam logic [11:0] ADDR_DATE      = 12'h014;
   localparam logic [11:0] ADDR_MONTH     = 12'h018;
   localparam logic [11:0] ADDR_YEAR      = 12'h01C;
   localparam logic [11:0] ADDR_WDAY      = 12'h020;
   // fields
   localparam int unsigned CTRL_BCD_BIT   = 0;
   localparam int unsigned CAL_UP_BIT     = 7;
   localparam int unsigned CAL_MAG_W      = 6;
   // limits and reset values, in binary
   localparam logic [15:0] SEC_MAX        = 16'h003B;
   localparam logic [15:0] HOUR_MAX       = 16'h0017;
   localparam logic [15:0] MONTH_MAX      = 16'h000C;
   localparam logic [15:0] YEAR_MAX       = 16'h270F;
   localparam logic [15:0] WDAY_MAX       = 16'h0006;
   localparam logic [15:0] FIELD_ZERO     = 16'h0000;
   localparam logic [15:0] FIELD_ONE      = 16'h0001;
   localparam logic [7:0]  CTRL_RST       = 8'h00;
   localparam logic [7:0]  CAL_RST        = 8'h00;

   typedef struct packed {
      logic [15:0] year;
      logic [7:0]  month_count;
      logic [7:0]  date;
      logic [7:0]  weekday_count;
      logic [7:0]  hours;
      logic [7:0]  minutes;
      logic [7:0]  seconds_count;
   } rfc_time_t;

   localparam rfc_time_t TIME_RST = '{year: 16'h0000, month_count: 8'h01, date: 8'h01,
                                      weekday_count: 8'h00, hours: 8'h00, minutes: 8'h00,
                                      seconds_count: 8'h00};
endpackage

// ### design/rfc_top.sv
// calendar clock with frequency calibration behind an axi4-lite slave
`timescale 1ns/1ps
module rfc_top #(
   parameter int unsigned SEC_CYCLES = rfc_pkg::SEC_CYCLES_DEF
) (
   // clock and reset
   input  wire logic                        aclk,
   input  wire logic                        aresetn,
   // write address and data
   input  wire logic [rfc_pkg::ADDR_W-1:0]  awaddr,
   input  wire logic                        awvalid,
   output logic                             awready,
   input  wire logic [31:0]                 wdata,
   input  wire logic [3:0]                  wstrb,
   input  wire logic                        wvalid,
   output logic                             wready,
   // write response
   output logic [1:0]                       bresp,
   output logic                             bvalid,
   input  wire logic                        bready,
   // read
   input  wire logic [rfc_pkg::ADDR_W-1:0]  araddr,
   input  wire logic                        arvalid,
   output logic                             arready,
   output logic [31:0]                      rdata,
   output logic [1:0]                       rresp,
   output logic                             rvalid,
   input  wire logic                        rready,
   // one pulse per counted second
   output logic                             second_tick
);
   import rfc_pkg::*;

   logic [ADDR_W-1:0] awaddr_q;
   logic [31:0]       wdata_q;
   logic [3:0]        wstrb_q;
   logic              aw_have_q, w_have_q, awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
   logic [1:0]        bresp_q, rresp_q;
   logic [31:0]       rdata_q, rd_word;
   logic              rd_hit;
   logic              wr_go, wr_time, wr_hit, aw_have_d, w_have_d, bvalid_d, rvalid_d;
   logic [7:0]        ctrl_q, cal_q;
   rfc_time_t         time_q, time_inc;
   logic              sec_wrap, tick_raw, tick_pend_q, tick_go, tick_q;
   logic [31:0]       cnt_q, reload, adj;
   logic [15:0]       step;

   // bcd or binary increment with wrap, returns {carry, value}
   function automatic logic [16:0] fld_inc(input logic [15:0] v, input logic [15:0] lo,
                                           input logic [15:0] hi, input logic bcd);
      logic [15:0] r;
      logic        c;
      r = v + 16'h0001;
      if (bcd) begin
         r = v;
         c = 1'b1;
         for (int i = 0; i < 4; i++) begin
            if (c) begin
               if (r[4*i+:4] == 4'h9) begin
                  r[4*i+:4] = 4'h0;
               end else begin
                  r[4*i+:4] = r[4*i+:4] + 4'h1;
                  c = 1'b0;
               end
            end
         end
      end
      if (v == (bcd ? bin2bcd(hi) : hi)) begin
         return {1'b1, (bcd ? bin2bcd(lo) : lo)};
      end
      return {1'b0, r};
   endfunction

   function automatic logic [15:0] bin2bcd(input logic [15:0] b);
      logic [15:0] r;
      r[3:0]   = 4'((b) % 16'h000A);
      r[7:4]   = 4'((b / 16'h000A) % 16'h000A);
      r[11:8]  = 4'((b / 16'h0064) % 16'h000A);
      r[15:12] = 4'((b / 16'h03E8) % 16'h000A);
      return r;
   endfunction

   function automatic logic [15:0] to_bin(input logic [15:0] v, input logic bcd);
      if (!bcd) begin
         return v;
      end
      return 16'(v[15:12]) * 16'h03E8 + 16'(v[11:8]) * 16'h0064 + 16'(v[7:4]) * 16'h000A + 16'(v[3:0]);
   endfunction

   function automatic logic [15:0] month_days(input logic [15:0] m, input logic leap);
      unique case (m)
         16'h0002: return leap ? 16'h001D : 16'h001C;
         16'h0004, 16'h0006, 16'h0009, 16'h000B: return 16'h001E;
         default: return 16'h001F;
      endcase
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[8*i+:8] = nw[8*i+:8];
         end
      end
      return r;
   endfunction

   function automatic logic is_time(input logic [ADDR_W-1:0] a);
      return a == ADDR_SEC || a == ADDR_MIN || a == ADDR_HOUR || a == ADDR_DATE ||
             a == ADDR_MONTH || a == ADDR_YEAR || a == ADDR_WDAY;
   endfunction

   // write channel handshakes
   always_comb begin
      wr_go     = aw_have_q && w_have_q && !bvalid_q;
      wr_hit    = (awaddr_q == ADDR_CTRL) || (awaddr_q == ADDR_CAL) || is_time(awaddr_q);
      wr_time   = wr_go && is_time(awaddr_q);
      aw_have_d = wr_go ? 1'b0 : (aw_have_q || (awvalid && awready_q));
      w_have_d  = wr_go ? 1'b0 : (w_have_q || (wvalid && wready_q));
      bvalid_d  = wr_go || (bvalid_q && !bready);
      rvalid_d  = (arvalid && arready_q) || (rvalid_q && !rready);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q <= 1'b0;
         w_have_q  <= 1'b0;
         awready_q <= 1'b0;
         wready_q  <= 1'b0;
         bvalid_q  <= 1'b0;
         bresp_q   <= RESP_OKAY;
         awaddr_q  <= '0;
         wdata_q   <= '0;
         wstrb_q   <= '0;
      end else begin
         aw_have_q <= aw_have_d;
         w_have_q  <= w_have_d;
         awready_q <= !aw_have_d && !bvalid_d;
         wready_q  <= !w_have_d && !bvalid_d;
         bvalid_q  <= bvalid_d;
         if (awvalid && awready_q) begin
            awaddr_q <= awaddr;
         end
         if (wvalid && wready_q) begin
            wdata_q <= wdata;
            wstrb_q <= wstrb;
         end
         if (wr_go) begin
            bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end
      end
   end

   // read channel
   always_comb begin
      rd_hit  = 1'b1;
      rd_word = '0;
      unique case (araddr)
         ADDR_CTRL:  rd_word = 32'(ctrl_q);
         ADDR_CAL:   rd_word = 32'(cal_q);
         ADDR_SEC:   rd_word = 32'(time_q.seconds_count);
         ADDR_MIN:   rd_word = 32'(time_q.minutes);
         ADDR_HOUR:  rd_word = 32'(time_q.hours);
         ADDR_DATE:  rd_word = 32'(time_q.date);
         ADDR_MONTH: rd_word = 32'(time_q.month_count);
         ADDR_YEAR:  rd_word = 32'(time_q.year);
         ADDR_WDAY:  rd_word = 32'(time_q.weekday_count);
         default:    rd_hit  = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_q <= 1'b0;
         rvalid_q  <= 1'b0;
         rdata_q   <= '0;
         rresp_q   <= RESP_OKAY;
      end else begin
         arready_q <= !rvalid_d;
         rvalid_q  <= rvalid_d;
         if (arvalid && arready_q) begin
            rdata_q <= rd_word;
            rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
         end
      end
   end

   // control and calibration registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_q <= CTRL_RST;
         cal_q  <= CAL_RST;
      end else if (wr_go && awaddr_q == ADDR_CTRL) begin
         ctrl_q <= 8'(merge(32'(ctrl_q), wdata_q, wstrb_q));
      end else if (wr_go && awaddr_q == ADDR_CAL) begin
         cal_q  <= 8'(merge(32'(cal_q), wdata_q, wstrb_q));
      end
   end

   // next calendar value for one second
   always_comb begin
      logic        bcd, c;
      logic [16:0] r;
      logic [15:0] yb;
      bcd      = ctrl_q[CTRL_BCD_BIT];
      time_inc = time_q;
      yb       = to_bin(time_q.year, bcd);
      r        = fld_inc(16'(time_q.seconds_count), FIELD_ZERO, SEC_MAX, bcd);
      time_inc.seconds_count = r[7:0];
      c        = r[16];
      sec_wrap = r[16];
      if (c) begin
         r = fld_inc(16'(time_q.minutes), FIELD_ZERO, SEC_MAX, bcd);
         time_inc.minutes = r[7:0];
         c = r[16];
      end
      if (c) begin
         r = fld_inc(16'(time_q.hours), FIELD_ZERO, HOUR_MAX, bcd);
         time_inc.hours = r[7:0];
         c = r[16];
      end
      if (c) begin
         r = fld_inc(16'(time_q.weekday_count), FIELD_ZERO, WDAY_MAX, bcd);
         time_inc.weekday_count = r[7:0];
         r = fld_inc(16'(time_q.date), FIELD_ONE,
                     month_days(to_bin(16'(time_q.month_count), bcd), yb[1:0] == 2'h0), bcd);
         time_inc.date = r[7:0];
         c = r[16];
      end
      if (c) begin
         r = fld_inc(16'(time_q.month_count), FIELD_ONE, MONTH_MAX, bcd);
         time_inc.month_count = r[7:0];
         c = r[16];
      end
      if (c) begin
         r = fld_inc(time_q.year, FIELD_ZERO, YEAR_MAX, bcd);
         time_inc.year = r[15:0];
      end
   end

   // calibration step and prescaler reload
   always_comb begin
      if (ctrl_q[CTRL_BCD_BIT]) begin
         step = cal_q[CAL_UP_BIT] ? STEP_UP_BCD : STEP_DN_BCD;
      end else begin
         step = cal_q[CAL_UP_BIT] ? STEP_UP_BIN : STEP_DN_BIN;
      end
      adj    = 32'(cal_q[CAL_MAG_W-1:0]) * 32'(step);
      reload = SEC_CYCLES - 32'h0000_0001;
      if (sec_wrap) begin
         reload = cal_q[CAL_UP_BIT] ? reload - adj : reload + adj;
      end
      tick_raw = (cnt_q == '0);
      tick_go  = (tick_raw || tick_pend_q) && !wr_time;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_q <= SEC_CYCLES - 32'h0000_0001;
      end else begin
         cnt_q <= tick_raw ? reload : cnt_q - 32'h0000_0001;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tick_pend_q <= 1'b0;
         tick_q      <= 1'b0;
      end else begin
         tick_pend_q <= (tick_raw || tick_pend_q) && wr_time;
         tick_q      <= tick_go;
      end
   end

   // calendar fields: a write touches its own field only
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         time_q <= TIME_RST;
      end else if (wr_time) begin
         unique case (awaddr_q)
            ADDR_SEC:   time_q.seconds_count <= 8'(merge(32'(time_q.seconds_count), wdata_q, wstrb_q));
            ADDR_MIN:   time_q.minutes       <= 8'(merge(32'(time_q.minutes), wdata_q, wstrb_q));
            ADDR_HOUR:  time_q.hours         <= 8'(merge(32'(time_q.hours), wdata_q, wstrb_q));
            ADDR_DATE:  time_q.date          <= 8'(merge(32'(time_q.date), wdata_q, wstrb_q));
            ADDR_MONTH: time_q.month_count   <= 8'(merge(32'(time_q.month_count), wdata_q, wstrb_q));
            ADDR_YEAR:  time_q.year          <= 16'(merge(32'(time_q.year), wdata_q, wstrb_q));
            default:    time_q.weekday_count <= 8'(merge(32'(time_q.weekday_count), wdata_q, wstrb_q));
         endcase
      end else if (tick_go) begin
         time_q <= time_inc;
      end
   end

   assign awready     = awready_q;
   assign wready      = wready_q;
   assign bvalid      = bvalid_q;
   assign bresp       = bresp_q;
   assign arready     = arready_q;
   assign rvalid      = rvalid_q;
   assign rdata       = rdata_q;
   assign rresp       = rresp_q;
   assign second_tick = tick_q;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   bin_up_step_a: assert property (tick_raw && sec_wrap && !ctrl_q[CTRL_BCD_BIT] && cal_q[CAL_UP_BIT] |=>
      cnt_q == SEC_CYCLES - 32'h1 - 32'($past(cal_q[CAL_MAG_W-1:0])) * 32'h200)
      else $error("binary up step wrong");
   bin_dn_step_a: assert property (tick_raw && sec_wrap && !ctrl_q[CTRL_BCD_BIT] && !cal_q[CAL_UP_BIT] |=>
      cnt_q == SEC_CYCLES - 32'h1 + 32'($past(cal_q[CAL_MAG_W-1:0])) * 32'h100)
      else $error("binary down step wrong");
   bcd_up_step_a: assert property (tick_raw && sec_wrap && ctrl_q[CTRL_BCD_BIT] && cal_q[CAL_UP_BIT] |=>
      cnt_q == SEC_CYCLES - 32'h1 - 32'($past(cal_q[CAL_MAG_W-1:0])) * 32'h400)
      else $error("bcd up step wrong");
   bcd_dn_step_a: assert property (tick_raw && sec_wrap && ctrl_q[CTRL_BCD_BIT] && !cal_q[CAL_UP_BIT] |=>
      cnt_q == SEC_CYCLES - 32'h1 + 32'($past(cal_q[CAL_MAG_W-1:0])) * 32'h200)
      else $error("bcd down step wrong");
   plain_second_a: assert property (tick_raw && !sec_wrap |=> cnt_q == SEC_CYCLES - 32'h1)
      else $error("uncorrected second reloaded wrong");
   sec_write_only_a: assert property (wr_go && awaddr_q == ADDR_SEC |=>
      $stable(time_q.minutes) && $stable(time_q.hours) && $stable(time_q.year) && $stable(cal_q))
      else $error("seconds write disturbed other registers");
   year_write_only_a: assert property (wr_go && awaddr_q == ADDR_YEAR |=>
      $stable(time_q.seconds_count) && $stable(time_q.date) && $stable(time_q.month_count))
      else $error("year write disturbed other registers");
   tick_kept_a: assert property (tick_raw && wr_time |=> tick_pend_q ##1 second_tick)
      else $error("second lost under a time write");
endmodule // rfc_top

// ### verification/testbench.sv
// self-checking bench for the calibrated calendar clock
`timescale 1ns/1ps
module testbench;
   import rfc_pkg::*;
   localparam int unsigned SEC_C = 4000;
   logic                aclk;
   logic                aresetn;
   logic [ADDR_W-1:0]   awaddr;
   logic                awvalid;
   logic                awready;
   logic [31:0]         wdata;
   logic [3:0]          wstrb;
   logic                wvalid;
   logic                wready;
   logic [1:0]          bresp;
   logic                bvalid;
   logic                bready;
   logic [ADDR_W-1:0]   araddr;
   logic                arvalid;
   logic                arready;
   logic [31:0]         rdata;
   logic [1:0]          rresp;
   logic                rvalid;
   logic                rready;
   logic                second_tick;
   logic [33:0]         rq[$];
   logic [1:0]          bq[$];
   int                  bad_count;
   int                  n_tests;
   int                  cnt;
   int                  k;
   logic [15:0]         step;
   logic [31:0]         vals[7];
   logic [31:0]         rv[9] = '{32'(CTRL_RST), 32'(CAL_RST), 32'h0, 32'h0, 32'h0, 32'h1, 32'h1, 32'h0, 32'h0};

   rfc_top #(.SEC_CYCLES(SEC_C)) u_rfc_top (
      .aclk(aclk), .aresetn(aresetn),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .second_tick(second_tick)
   );

   initial begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end

   task automatic check(input logic [33:0] got, input logic [33:0] exp);
      n_tests++;
      if (got !== exp) begin
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
         bad_count++;
      end
   endtask

   task automatic wrap_up;
      $display("mismatches %0d, comparisons %0d", bad_count, n_tests);
      if (bad_count == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // bounded wait ran out
   task automatic lim(input int n, input int m);
      if (n >= m) begin
         $display("ERROR at %0t: got %h expected %h", $time, n, m - 1);
         bad_count++;
         wrap_up();
      end
   endtask

   // whole aligned word write, response noted in queue
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      @(posedge aclk);
      bq.push_back(er);
      awaddr  <= a;
      wdata   <= d;
      wstrb   <= 4'hF;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      n = 0;
      do begin
         @(posedge aclk);
         n++;
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!(bvalid && bready) && n < 100);
      bready <= 1'b0;
      lim(n, 100);
   endtask

   // read, expected response and data noted in queue
   task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
      int n;
      @(posedge aclk);
      rq.push_back({er, ed});
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      n = 0;
      do begin
         @(posedge aclk);
         n++;
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!(rvalid && rready) && n < 100);
      rready <= 1'b0;
      lim(n, 100);
   endtask

   // edges up to and including the next tick
   task automatic tick_wait(output int n);
      n = 0;
      do begin
         @(posedge aclk);
         n++;
      end while (second_tick !== 1'b1 && n < 20000);
      lim(n, 20000);
   endtask

   // monitor of answers
   always @(posedge aclk) begin
      if (rvalid && rready) begin
         check({rresp, rdata}, rq.pop_front());
      end
      if (bvalid && bready) begin
         check({32'h0, bresp}, {32'h0, bq.pop_front()});
      end
   end

   initial begin
      aresetn = 1'b0;
      awaddr  = '0;
      awvalid = 1'b0;
      wdata   = '0;
      wstrb   = '0;
      wvalid  = 1'b0;
      bready  = 1'b0;
      araddr  = '0;
      arvalid = 1'b0;
      rready  = 1'b0;
      bad_count = 0;
      n_tests = 0;
      void'($urandom(21980));
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (3) @(posedge aclk);
      for (int i = 0; i < 9; i++) rd(12'(4 * i), rv[i], RESP_OKAY);
      rd(12'h100, 32'h0, RESP_SLVERR);
      wr(12'h100, 32'h0000_00FF, RESP_SLVERR);
      rd(ADDR_CTRL, 32'(CTRL_RST), RESP_OKAY);
      // fill time registers just after a tick, then read all back
      tick_wait(cnt);
      vals = '{$urandom_range(50, 0), $urandom_range(59, 0), $urandom_range(23, 0), $urandom_range(28, 1),
               $urandom_range(12, 1), $urandom_range(9999, 0), $urandom_range(6, 0)};
      for (int i = 0; i < 7; i++) wr(ADDR_SEC + 12'(4 * i), vals[i], RESP_OKAY);
      for (int i = 0; i < 7; i++) rd(ADDR_SEC + 12'(4 * i), vals[i], RESP_OKAY);
      // corrected second length in each mode and direction
      for (int m = 0; m < 2; m++) begin
         for (int u = 0; u < 2; u++) begin
            k = $urandom_range(3, 1);
            step = m ? (u ? STEP_UP_BCD : STEP_DN_BCD) : (u ? STEP_UP_BIN : STEP_DN_BIN);
            wr(ADDR_CTRL, 32'(m), RESP_OKAY);
            wr(ADDR_CAL, {24'h0, u[0], 1'b0, 6'(k)}, RESP_OKAY);
            wr(ADDR_SEC, m ? 32'h59 : 32'h3B, RESP_OKAY);
            tick_wait(cnt);
            tick_wait(cnt);
            check(34'(cnt), u ? 34'(SEC_C - k * step) : 34'(SEC_C + k * step));
            // half of a wanted 2k loaded in bcd gives the binary-sized correction
            if (m == 1) begin
               step = u ? STEP_UP_BIN : STEP_DN_BIN;
               check(34'(cnt), u ? 34'(SEC_C - 2 * k * step) : 34'(SEC_C + 2 * k * step));
            end
            rd(ADDR_SEC, 32'h1, RESP_OKAY);
         end
      end
      // time write landing on the tick edge defers the advance one cycle
      tick_wait(cnt);
      repeat (SEC_C - 4) @(posedge aclk);
      k = $urandom_range(59, 0);
      wr(ADDR_MIN, 32'(k), RESP_OKAY);
      tick_wait(cnt);
      check(34'(cnt), 34'h1);
      rd(ADDR_MIN, 32'(k), RESP_OKAY);
      rd(ADDR_SEC, 32'h3, RESP_OKAY);
      wrap_up();
   end
endmodule // testbench
